// *** logic/wit_pkg.sv ***
package wit_pkg;

   // One bus state is one mclk cycle at 10 MHz
   localparam int          CLK_PERIOD_NS  = 100;
   localparam int          STATE_CYCLES   = 1;
   localparam int          INT_RST_STATES = 518;
   localparam int          EXT_RST_STATES = 132;
   localparam logic [9:0]  INT_RST_CYC    = 10'(INT_RST_STATES * STATE_CYCLES);
   localparam logic [9:0]  EXT_RST_CYC    = 10'(EXT_RST_STATES * STATE_CYCLES);

   localparam logic [7:0]  OFS_CNT_CTRL   = 8'h00;
   localparam logic [7:0]  OFS_INIT       = 8'h04;

   localparam logic [7:0]  KEY_COUNT      = 8'h5a;
   localparam logic [7:0]  KEY_CTRL       = 8'ha5;
   localparam logic [7:0]  KEY_INIT_CLR   = 8'ha5;
   localparam logic [7:0]  KEY_INIT_OE    = 8'h5a;

   localparam int          CTRL_WRAP_BIT  = 7;
   localparam int          CTRL_MODE_BIT  = 6;
   localparam int          CTRL_RUN_BIT   = 5;
   localparam int          CTRL_CKS_LSB   = 0;
   localparam int          INIT_FLAG_BIT  = 7;
   localparam int          INIT_OE_BIT    = 6;
   localparam logic [7:0]  CTRL_RESV      = 8'h18;
   localparam logic [7:0]  INIT_RESV      = 8'h3f;

   localparam logic [7:0]  COUNT_RST      = 8'h00;
   localparam logic [7:0]  COUNT_MAX      = 8'hff;
   localparam logic [1:0]  RESP_OKAY      = 2'h0;
   localparam logic [1:0]  RESP_SLVERR    = 2'h2;

   typedef struct packed {
      logic       counter_wrap_flag;
      logic       mode_select_watch_or_interval;
      logic       timer_run_enable;
      logic [2:0] prescale_select;
   } wit_ctrl_t;

   localparam wit_ctrl_t   CTRL_RST       = '0;

   // Low-bit mask of the prescaler for each select code
   function automatic logic [11:0] wit_div_mask(input logic [2:0] sel);
      case (sel)
         3'h0:    wit_div_mask = 12'h001;
         3'h1:    wit_div_mask = 12'h01f;
         3'h2:    wit_div_mask = 12'h03f;
         3'h3:    wit_div_mask = 12'h07f;
         3'h4:    wit_div_mask = 12'h0ff;
         3'h5:    wit_div_mask = 12'h1ff;
         3'h6:    wit_div_mask = 12'h7ff;
         default: wit_div_mask = 12'hfff;
      endcase
   endfunction

endpackage

// *** logic/wit_prescaler.sv ***
`timescale 1ns/1ps
module wit_prescaler
   import wit_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic       rstn,
   input  wire logic       clr,
   input  wire logic [2:0] sel,
   output logic            tick
);

   logic [11:0] div;

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         div <= 12'h000;
      end else if (clr) begin
         div <= 12'h000;
      end else begin
         div <= div + 12'h001;
      end
   end

   assign tick = ((div & wit_div_mask(sel)) == wit_div_mask(sel)) && !clr; // R20

   property p_tick_div2;
      (sel == 3'h0) && tick && !clr ##1 (sel == 3'h0) && !clr |-> !tick;
   endproperty
   a_tick_div2: assert property (@(posedge mclk) disable iff (!rstn) p_tick_div2) // R20
      else $error("Divide-by-2 tick on consecutive cycles");

endmodule

// *** logic/wit_pulse_timer.sv ***
`timescale 1ns/1ps
module wit_pulse_timer
   import wit_pkg::*;
#(
   parameter logic [9:0] LEN = 10'd1
)
(
   input  wire logic mclk,
   input  wire logic rstn,
   input  wire logic start,
   output logic      active
);

   logic [9:0] left;
   logic [9:0] run_len;

   // A start while running is ignored: the pulse is never stretched
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         left <= 10'd0;
      end else if (start && left == 10'd0) begin
         left <= LEN;
      end else if (left != 10'd0) begin
         left <= left - 10'd1;
      end
   end

   assign active = (left != 10'd0);

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         run_len <= 10'd0;
      end else if (active) begin
         run_len <= run_len + 10'd1;
      end else begin
         run_len <= 10'd0;
      end
   end

   property p_pulse_len;
      $fell(active) |-> run_len == LEN;
   endproperty
   a_pulse_len: assert property (@(posedge mclk) disable iff (!rstn) p_pulse_len) // R03
      else $error("Reset pulse length wrong");

endmodule

// *** logic/wit_watchdog_unit.sv ***
// Contract
// R01 - Watchdog mode when mode select and run enable are both one.
// R02 - Software rewrites the counter, usually to zero, before it overflows.
// R03 - Watchdog overflow raises an internal chip reset for 518 states.
// R04 - Watchdog overflow with output enabled drives the init pin for 132 states.
// R05 - The init pin carries the watchdog reset only when its enable bit is one.
// R06 - Watchdog reset shares the pin reset vector; the init flag tells them apart.
// R07 - Simultaneous pin and watchdog resets count as a pin reset.
// R08 - Interval mode with run enabled requests an interrupt every overflow.
// R09 - Every overflow sets the wrap flag and fires reset or interrupt same cycle.
// R10 - The watchdog init flag is meaningful only in watchdog mode.
// R11 - In watchdog mode the init flag sets with the wrap flag on overflow.
// R12 - The internal reset clears the wrap flag but keeps the init flag.
// R13 - Software clears the init flag itself after a watchdog reset.
// R14 - In interval mode the interrupt is requested while the wrap flag is one.
// R15 - A counter write meeting a tick stores the data and skips the increment.
// R16 - Software stops the counter before changing the prescale select.
// R17 - Overflow is the counter stepping from its maximum to zero.
// R18 - Run enable zero holds the counter at zero; one lets it count.
// R19 - Writes are word writes keyed by a password in the upper byte.
// R20 - Prescale select picks one of eight clock divisions, 2 to 4096.
// R21 - While running the counter increments once per prescaled tick.
`timescale 1ns/1ps
module wit_watchdog_unit
   import wit_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        rstn,
   input  wire logic [31:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [31:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic             chip_reset_int,
   output logic             chip_init_output_n,
   output logic             interval_overflow_irq
);

   wit_ctrl_t   wdog_ctrl_status;
   logic [7:0]  wdog_count;
   logic        watchdog_init_flag;
   logic        init_output_enable;
   logic        wrap_armed;
   logic        flag_armed;

   logic        aw_hold;
   logic        w_hold;
   logic [7:0]  aw_ofs;
   logic [15:0] w_word;
   logic        w_full;

   logic        tick;
   logic        ext_active;

   // Bus decode
   wire         do_wr      = aw_hold && w_hold;
   wire         wr_cc      = do_wr && aw_ofs == OFS_CNT_CTRL;
   wire         wr_init    = do_wr && aw_ofs == OFS_INIT;
   wire         wr_mapped  = wr_cc || wr_init;
   wire  [7:0]  key        = w_word[15:8];
   wire  [7:0]  wbyte      = w_word[7:0];
   wire         ar_take    = s_axi_arvalid && s_axi_arready;
   wire  [7:0]  ar_ofs     = s_axi_araddr[7:0];
   wire         ar_cc      = ar_ofs == OFS_CNT_CTRL;
   wire         ar_init    = ar_ofs == OFS_INIT;

   // Keyed writes; byte writes are refused
   wire         cnt_wr     = wr_cc && w_full && key == KEY_COUNT; // R19
   wire         ctrl_wr    = wr_cc && w_full && key == KEY_CTRL; // R19
   wire         init_clr   = wr_init && w_full && key == KEY_INIT_CLR
                             && wbyte == 8'h00; // R19
   wire         init_oe_wr = wr_init && w_full && key == KEY_INIT_OE; // R19

   // Mode and counting
   wire         run        = wdog_ctrl_status.timer_run_enable;
   wire         wd_mode    = wdog_ctrl_status.mode_select_watch_or_interval && run; // R01
   wire         iv_mode    = !wdog_ctrl_status.mode_select_watch_or_interval && run; // R08
   wire         count_tick = tick && run && !cnt_wr && !chip_reset_int; // R15 R21
   wire         ovf        = count_tick && wdog_count == COUNT_MAX; // R17
   wire         wd_ovf     = ovf && wd_mode; // R09

   // Flag clear needs a prior read that saw the flag set
   wire         wrap_clr   = ctrl_wr && flag_clr_bit(wbyte, CTRL_WRAP_BIT) && wrap_armed;
   wire         flag_clr   = init_clr && flag_armed; // R13

   function automatic logic flag_clr_bit(input logic [7:0] b, input int pos);
      flag_clr_bit = !b[pos];
   endfunction

   wire  [7:0]  ctrl_byte  = {wdog_ctrl_status.counter_wrap_flag,
                              wdog_ctrl_status.mode_select_watch_or_interval,
                              wdog_ctrl_status.timer_run_enable,
                              2'b00,
                              wdog_ctrl_status.prescale_select} | CTRL_RESV;
   wire  [7:0]  init_byte  = {watchdog_init_flag, init_output_enable, 6'h00} | INIT_RESV;

   assign s_axi_awready = !aw_hold && !s_axi_bvalid;
   assign s_axi_wready  = !w_hold && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;

   wit_prescaler u_prescaler (
      .mclk (mclk),
      .rstn (rstn),
      .clr  (!run || chip_reset_int),
      .sel  (wdog_ctrl_status.prescale_select),
      .tick (tick)
   );

   wit_pulse_timer #(
      .LEN (INT_RST_CYC)
   ) u_int_reset (
      .mclk   (mclk),
      .rstn   (rstn),
      .start  (wd_ovf), // R03
      .active (chip_reset_int)
   );

   wit_pulse_timer #(
      .LEN (EXT_RST_CYC)
   ) u_ext_reset (
      .mclk   (mclk),
      .rstn   (rstn),
      .start  (wd_ovf && init_output_enable), // R04 R05
      .active (ext_active)
   );

   assign chip_init_output_n    = !ext_active; // R05
   assign interval_overflow_irq = wdog_ctrl_status.counter_wrap_flag
                                  && !wdog_ctrl_status.mode_select_watch_or_interval; // R14

   // Write address and data channels, taken in either order
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         aw_hold <= 1'b0;
         aw_ofs  <= 8'h00;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_hold <= 1'b1;
         aw_ofs  <= s_axi_awaddr[7:0];
      end else if (do_wr) begin
         aw_hold <= 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         w_hold <= 1'b0;
         w_word <= 16'h0000;
         w_full <= 1'b0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_hold <= 1'b1;
         w_word <= s_axi_wdata[15:0];
         w_full <= &s_axi_wstrb[1:0];
      end else if (do_wr) begin
         w_hold <= 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else if (do_wr) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= RESP_OKAY;
      end else if (ar_take) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= ar_cc   ? {16'h0000, wdog_count, ctrl_byte} :
                         ar_init ? {24'h000000, init_byte} : 32'h0000_0000;
         s_axi_rresp  <= (ar_cc || ar_init) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // Clear arms; a flag read as one may then be written to zero
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         wrap_armed <= 1'b0;
         flag_armed <= 1'b0;
      end else begin
         if (!wdog_ctrl_status.counter_wrap_flag) begin
            wrap_armed <= 1'b0;
         end else if (ar_take && ar_cc) begin
            wrap_armed <= 1'b1;
         end
         if (!watchdog_init_flag) begin
            flag_armed <= 1'b0;
         end else if (ar_take && ar_init) begin
            flag_armed <= 1'b1;
         end
      end
   end

   // Control and counter; the internal reset holds both at reset values
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         wdog_ctrl_status <= CTRL_RST;
      end else if (chip_reset_int) begin
         wdog_ctrl_status <= CTRL_RST; // R12
      end else begin
         if (ovf) begin
            wdog_ctrl_status.counter_wrap_flag <= 1'b1; // R09
         end else if (wrap_clr) begin
            wdog_ctrl_status.counter_wrap_flag <= 1'b0;
         end
         if (ctrl_wr) begin
            wdog_ctrl_status.mode_select_watch_or_interval <= wbyte[CTRL_MODE_BIT];
            wdog_ctrl_status.timer_run_enable              <= wbyte[CTRL_RUN_BIT];
            wdog_ctrl_status.prescale_select <= wbyte[CTRL_CKS_LSB +: 3]; // R16
         end
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         wdog_count <= COUNT_RST;
      end else if (chip_reset_int || !run) begin
         wdog_count <= COUNT_RST; // R18
      end else if (cnt_wr) begin
         wdog_count <= wbyte; // R15
      end else if (count_tick) begin
         wdog_count <= wdog_count + 8'h01; // R21
      end
   end

   // The pin reset or an armed software clear clears the init flag; the pin reset wins a tie
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         watchdog_init_flag <= 1'b0; // R07
         init_output_enable <= 1'b0;
      end else begin
         if (wd_ovf) begin
            watchdog_init_flag <= 1'b1; // R06 R10 R11
         end else if (flag_clr) begin
            watchdog_init_flag <= 1'b0; // R13
         end
         if (init_oe_wr) begin
            init_output_enable <= wbyte[INIT_OE_BIT];
         end
      end
   end

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rstn);

   sequence s_wd_wrap;
      ovf && wd_mode;
   endsequence

   sequence s_iv_wrap;
      ovf && iv_mode;
   endsequence

   property p_int_reset;
      s_wd_wrap |=> chip_reset_int [*8];
   endproperty
   a_int_reset: assert property (p_int_reset) // R03
      else $error("Internal reset missing after watchdog wrap");

   property p_ext_on;
      s_wd_wrap ##0 init_output_enable && !ext_active |=> !chip_init_output_n [*4];
   endproperty
   a_ext_on: assert property (p_ext_on) // R04
      else $error("Init output not driven after watchdog wrap");

   property p_ext_off;
      !ext_active && !(wd_ovf && init_output_enable) |=> chip_init_output_n;
   endproperty
   a_ext_off: assert property (p_ext_off) // R05
      else $error("Init output driven without enable");

   property p_wrap_set;
      s_iv_wrap |=> wdog_ctrl_status.counter_wrap_flag && interval_overflow_irq;
   endproperty
   a_wrap_set: assert property (p_wrap_set) // R09
      else $error("Interval wrap did not set flag and request");

   property p_flag_set;
      s_wd_wrap |=> watchdog_init_flag && wdog_ctrl_status.counter_wrap_flag;
   endproperty
   a_flag_set: assert property (p_flag_set) // R11
      else $error("Init flag not set with wrap flag");

   property p_flag_mode;
      $rose(watchdog_init_flag) |-> $past(wd_mode);
   endproperty
   a_flag_mode: assert property (p_flag_mode) // R10
      else $error("Init flag set outside watchdog mode");

   property p_reset_clears;
      s_wd_wrap ##1 1'b1 |=> !wdog_ctrl_status.counter_wrap_flag && watchdog_init_flag;
   endproperty
   a_reset_clears: assert property (p_reset_clears) // R12
      else $error("Internal reset did not clear wrap flag or lost init flag");

   property p_irq;
      $rose(interval_overflow_irq) |-> $past(ovf) || $past(ctrl_wr);
   endproperty
   a_irq: assert property (p_irq) // R14
      else $error("Interval request raised without a wrap");

   property p_write_wins;
      cnt_wr && tick && run && !chip_reset_int |=> wdog_count == $past(wbyte);
   endproperty
   a_write_wins: assert property (p_write_wins) // R15
      else $error("Counter write lost to a tick");

   property p_wrap_zero;
      ovf |=> wdog_count == 8'h00;
   endproperty
   a_wrap_zero: assert property (p_wrap_zero) // R17
      else $error("Counter not zero after wrap");

   property p_halt;
      !run |=> wdog_count == 8'h00;
   endproperty
   a_halt: assert property (p_halt) // R18
      else $error("Counter moved while halted");

   property p_step;
      count_tick && wdog_count != COUNT_MAX |=> wdog_count == $past(wdog_count) + 8'h01;
   endproperty
   a_step: assert property (p_step) // R21
      else $error("Counter did not step by one");

endmodule

// *** bench/watchdog_interval_timer_tb.sv ***
`timescale 1ns/1ps
module watchdog_interval_timer_tb;
   import wit_pkg::*;

   logic        mclk;
   logic        rstn;
   logic [31:0] awaddr;
   logic        awvalid;
   logic        awready;
   logic [31:0] wdata;
   logic [3:0]  wstrb;
   logic        wvalid;
   logic        wready;
   logic [1:0]  bresp;
   logic        bvalid;
   logic        bready;
   logic [31:0] araddr;
   logic        arvalid;
   logic        arready;
   logic [31:0] rdata;
   logic [1:0]  rresp;
   logic        rvalid;
   logic        rready;
   logic        rst_int;
   logic        init_n;
   logic        irq;
   int          num_errors  = 0;
   int          comparisons = 0;
   logic [31:0] rd;
   logic [1:0]  rp;

   wit_watchdog_unit dut (
      .mclk                  (mclk),
      .rstn                  (rstn),
      .s_axi_awaddr          (awaddr),
      .s_axi_awvalid         (awvalid),
      .s_axi_awready         (awready),
      .s_axi_wdata           (wdata),
      .s_axi_wstrb           (wstrb),
      .s_axi_wvalid          (wvalid),
      .s_axi_wready          (wready),
      .s_axi_bresp           (bresp),
      .s_axi_bvalid          (bvalid),
      .s_axi_bready          (bready),
      .s_axi_araddr          (araddr),
      .s_axi_arvalid         (arvalid),
      .s_axi_arready         (arready),
      .s_axi_rdata           (rdata),
      .s_axi_rresp           (rresp),
      .s_axi_rvalid          (rvalid),
      .s_axi_rready          (rready),
      .chip_reset_int        (rst_int),
      .chip_init_output_n    (init_n),
      .interval_overflow_irq (irq)
   );

   initial begin
      mclk = 1'b0;
      forever #(CLK_PERIOD_NS / 2) mclk = ~mclk;
   end

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic hang(input string what);
      num_errors++;
      $display("BAD %s expected event seen none", what);
      give_verdict();
   endtask

   // Valid and payload held until the edge that samples ready
   task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [3:0] st = 4'hf);
      int n;
      @(posedge mclk);
      awaddr <= {24'h0, a};
      awvalid <= 1'b1;
      wdata <= {16'h0, d};
      wstrb <= st;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge mclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid && bready) begin
            rp = bresp;
            bready <= 1'b0;
            break;
         end
      end
      if (n == 50) hang("write response");
   endtask

   task automatic rdr(input logic [7:0] a);
      int n;
      @(posedge mclk);
      araddr <= {24'h0, a};
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge mclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid && rready) begin
            rd = rdata;
            rp = rresp;
            rready <= 1'b0;
            break;
         end
      end
      if (n == 50) hang("read data");
   endtask

   task automatic wait_sig(input bit sel, input int lim, output int cyc);
      for (cyc = 0; cyc < lim; cyc++) begin
         @(posedge mclk);
         if ((sel ? rst_int : irq) === 1'b1) break;
      end
      if (cyc == lim) hang(sel ? "internal reset" : "interval irq");
   endtask

   task automatic t_reset_vals();
      rdr(OFS_CNT_CTRL);
      chk("count and control", 32'h0018, rd);
      rdr(OFS_INIT);
      chk("init status", 32'h003f, rd);
      rdr(8'h08);
      chk("unmapped read resp", RESP_SLVERR, rp);
      wr(8'h08, 16'ha520);
      chk("unmapped write resp", RESP_SLVERR, rp);
      $display("reset values done");
   endtask

   task automatic t_keys();
      wr(OFS_CNT_CTRL, {KEY_COUNT, 8'h77});
      rdr(OFS_CNT_CTRL);
      chk("count held while stopped", 32'h0018, rd);
      wr(OFS_CNT_CTRL, {KEY_CTRL, 8'h27}, 4'h1);
      wr(OFS_CNT_CTRL, {8'h3c, 8'h27});
      rdr(OFS_CNT_CTRL);
      chk("control after bad writes", 32'h0018, rd);
      wr(OFS_CNT_CTRL, {KEY_CTRL, 8'h27});
      wr(OFS_CNT_CTRL, {KEY_COUNT, 8'h42});
      rdr(OFS_CNT_CTRL);
      chk("keyed count and control", 32'h423f, rd);
      $display("keyed writes done");
   endtask

   task automatic t_interval();
      int c;
      wr(OFS_CNT_CTRL, {KEY_CTRL, 8'h00});
      wr(OFS_CNT_CTRL, {KEY_CTRL, 8'h20});
      wr(OFS_CNT_CTRL, {KEY_COUNT, 8'hfe});
      wait_sig(1'b0, 20, c);
      chk("no reset in interval", 1'b0, rst_int);
      rdr(OFS_CNT_CTRL);
      chk("wrap flag set", 8'hb8, rd[7:0]);
      chk("irq with flag", 1'b1, irq);
      rdr(OFS_INIT);
      chk("init flag idle", 8'h3f, rd[7:0]);
      wr(OFS_CNT_CTRL, {KEY_CTRL, 8'h20});
      chk("irq cleared", 1'b0, irq);
      rdr(OFS_CNT_CTRL);
      chk("wrap flag cleared", 8'h38, rd[7:0]);
      $display("interval mode done");
   endtask

   task automatic t_rates();
      int divs[8] = '{2, 32, 64, 128, 256, 512, 2048, 4096};
      int c;
      for (int k = 0; k < 8; k++) begin
         rdr(OFS_CNT_CTRL);
         wr(OFS_CNT_CTRL, {KEY_CTRL, 8'h00});
         wr(OFS_CNT_CTRL, {KEY_CTRL, 5'b00100, 3'(k)});
         wr(OFS_CNT_CTRL, {KEY_COUNT, 8'hfe});
         wait_sig(1'b0, 2 * divs[k] + 10, c);
         chk("two ticks span", 1'b1, c >= divs[k] && c <= 2 * divs[k] + 4);
      end
      rdr(OFS_CNT_CTRL);
      wr(OFS_CNT_CTRL, {KEY_CTRL, 8'h00});
      $display("prescale rates done");
   endtask

   // Kicks land well inside the 512 cycles a divide-by-2 count needs to wrap
   task automatic t_kick();
      int hits;
      hits = 0;
      wr(OFS_INIT, {KEY_INIT_OE, 8'h40});
      wr(OFS_CNT_CTRL, {KEY_CTRL, 8'h60});
      repeat (12) begin
         wr(OFS_CNT_CTRL, {KEY_COUNT, 8'h00});
         repeat (300) begin
            @(posedge mclk);
            hits += (rst_int === 1'b1) + (init_n === 1'b0);
         end
      end
      chk("resets while kicked", 0, hits);
      rdr(OFS_CNT_CTRL);
      chk("watchdog control", 8'h78, rd[7:0]);
      wr(OFS_CNT_CTRL, {KEY_CTRL, 8'h00});
      rdr(OFS_INIT);
      chk("init flag while kicked", 8'h7f, rd[7:0]);
      $display("watchdog kick done");
   endtask

   task automatic arm_watchdog(input bit oe);
      wr(OFS_INIT, {KEY_INIT_OE, 1'b0, oe, 6'h00});
      wr(OFS_CNT_CTRL, {KEY_CTRL, 8'h60});
      wr(OFS_CNT_CTRL, {KEY_COUNT, 8'hfe});
   endtask

   task automatic t_watchdog(input bit oe);
      int ri;
      int ei;
      int qi;
      ri = 0;
      ei = 0;
      qi = 0;
      arm_watchdog(oe);
      repeat (700) begin
         @(posedge mclk);
         ri += (rst_int === 1'b1);
         ei += (init_n === 1'b0);
         qi += (irq === 1'b1);
      end
      chk("internal reset length", 518, ri);
      chk("init output length", oe ? 132 : 0, ei);
      chk("irq in watchdog mode", 0, qi);
      rdr(OFS_INIT);
      chk("init flag kept", {1'b1, oe, 6'h3f}, rd[7:0]);
      rdr(OFS_CNT_CTRL);
      chk("wrap flag and control cleared", 32'h0018, rd);
      wr(OFS_INIT, {KEY_INIT_CLR, 8'h00});
      rdr(OFS_INIT);
      chk("init flag cleared", {1'b0, oe, 6'h3f}, rd[7:0]);
      $display("watchdog mode done");
   endtask

   task automatic t_pin_wins();
      int c;
      arm_watchdog(1'b1);
      wait_sig(1'b1, 20, c);
      @(posedge mclk);
      rstn <= 1'b0;
      @(posedge mclk);
      #1;
      chk("internal reset under pin reset", 1'b0, rst_int);
      chk("init output under pin reset", 1'b1, init_n);
      @(posedge mclk);
      rstn <= 1'b1;
      rdr(OFS_INIT);
      chk("init status after pin reset", 32'h003f, rd);
      rdr(OFS_CNT_CTRL);
      chk("control after pin reset", 32'h0018, rd);
      $display("pin reset priority done");
   endtask

   initial begin
      rstn = 1'b0;
      awaddr = '0;
      awvalid = 1'b0;
      wdata = '0;
      wstrb = '0;
      wvalid = 1'b0;
      bready = 1'b0;
      araddr = '0;
      arvalid = 1'b0;
      rready = 1'b0;
      repeat (12) @(posedge mclk);
      rstn <= 1'b1;
      t_reset_vals();
      t_keys();
      t_interval();
      t_rates();
      t_kick();
      t_watchdog(1'b1);
      t_watchdog(1'b0);
      t_pin_wins();
      give_verdict();
   end
endmodule
